// ### cwsd_defs.svh
`ifndef CWSD_DEFS_SVH
`define CWSD_DEFS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CWSD_OFF_CTRL 8'h00
`define CWSD_OFF_POL 8'h01
`define CWSD_OFF_DBR 8'h02
`define CWSD_OFF_IRQ_STAT 8'h03
`define CWSD_OFF_IRQ_MASK 8'h04
`define CWSD_OFF_PIN_STAT 8'h05

// ------------------------------------------------------------
// field positions and write masks
// ------------------------------------------------------------
`define CWSD_CTRL_WMASK 8'hf7
`define CWSD_POL_A_BIT 0
`define CWSD_POL_B_BIT 1
`define CWSD_DBR_W 6
`define CWSD_IRQ_W 3
`define CWSD_IRQ_SD_ENTER 0
`define CWSD_IRQ_SD_EXIT 1
`define CWSD_IRQ_DB_DONE 2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CWSD_CTRL_RST 8'h00
`define CWSD_POL_RST 2'h0
`define CWSD_DBR_RST 6'h00
`define CWSD_IRQ_RST 3'h0

`endif

// ### cwsd_pkg.sv
package cwsd_pkg;

   // ------------------------------------------------------------
   // shutdown state codes of one output
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CWSD_SD_INACTIVE = 2'h0,
      CWSD_SD_TRISTATE = 2'h1,
      CWSD_SD_LOW = 2'h2,
      CWSD_SD_HIGH = 2'h3
   } cwsd_sd_code_t;

   // control register layout, msb first
   typedef struct packed {
      cwsd_sd_code_t out_b_shutdown_state;
      cwsd_sd_code_t out_a_shutdown_state;
      logic unused_bit3;
      logic [2:0] input_source_select;
   } cwsd_ctrl_t;

   // one output pin: level and output enable
   typedef struct packed {
      logic level;
      logic oe;
   } cwsd_pin_t;

   // dead-band sequencer states
   typedef enum logic [2:0] {
      CWSD_DB_IDLE = 3'b001,
      CWSD_DB_COUNT = 3'b010,
      CWSD_DB_DONE = 3'b100
   } cwsd_db_state_t;

endpackage : cwsd_pkg

// ### cwsd_deadband.sv
`include "cwsd_defs.svh"

module cwsd_deadband (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic [`CWSD_DBR_W-1:0] count,
   // status
   output logic done
);
   import cwsd_pkg::*;

   cwsd_db_state_t state;
   cwsd_db_state_t next_state;
   logic [`CWSD_DBR_W-1:0] remain;
   logic [`CWSD_DBR_W-1:0] next_remain;

   // ------------------------------------------------------------
   // next state: abort wins, shutdown may end mid-count
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_remain = remain;
      unique case (state)
         CWSD_DB_IDLE: begin
            if (start) begin
               next_remain = count;
               next_state = (count == `CWSD_DBR_RST) ? CWSD_DB_DONE : CWSD_DB_COUNT;
            end
         end
         CWSD_DB_COUNT: begin
            next_remain = remain - 6'h01;
            if (remain == 6'h01) begin
               next_state = CWSD_DB_DONE;
            end
         end
         CWSD_DB_DONE: begin
            next_state = CWSD_DB_DONE;
         end
         default: begin
            next_state = CWSD_DB_IDLE;
         end
      endcase
      if (abort) begin
         next_state = CWSD_DB_IDLE;
      end
   end

   // state flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= CWSD_DB_IDLE;
         remain <= `CWSD_DBR_RST;
      end else begin
         state <= next_state;
         remain <= next_remain;
      end
   end

   assign done = (state == CWSD_DB_DONE);

endmodule : cwsd_deadband

// ### cwsd_top.sv
// Operation
// R01: shutdown fields apply only while shutdown present
// R02: B code 11 high, 10 low, polarity ignored
// R03: B code 01 tri-states pin B
// R04: B code 00 inactive after dead band, polarity
// R05: A code 11 high, 10 low, polarity ignored
// R06: A code 01 tri-states pin A
// R07: A code 00 inactive after dead band, polarity
// R08: three-bit field selects one of eight sources
// R09: control bit 3 ignores writes, reads zero
// R10: B field bits 7-6, A field 5-4
// R11: polarity one inverts the output
// R12: dead band n gives n to n+1 counts
`include "cwsd_defs.svh"

module cwsd_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // waveform sources
   input wire logic comparator1_async_output,
   input wire logic comparator2_async_output,
   input wire logic pwm_unit1_output,
   input wire logic pwm_unit2_output,
   input wire logic pwm_unit3_output,
   input wire logic pwm_unit4_output,
   input wire logic num_osc_output,
   input wire logic logic_cell1_output,
   // shutdown event from the shutdown source logic
   input wire logic shutdown_event_status,
   // output pins
   output cwsd_pkg::cwsd_pin_t output_pin_a,
   output cwsd_pkg::cwsd_pin_t output_pin_b,
   // interrupt
   output logic irq
);
   import cwsd_pkg::*;

   // ------------------------------------------------------------
   // registers and state
   // ------------------------------------------------------------
   cwsd_ctrl_t ctrl;
   logic out_a_polarity;
   logic out_b_polarity;
   logic [`CWSD_DBR_W-1:0] rising_deadband_count;
   logic [`CWSD_IRQ_W-1:0] irq_stat;
   logic [`CWSD_IRQ_W-1:0] irq_mask;
   logic sd_prev;
   logic db_done_prev;

   // ------------------------------------------------------------
   // decoded bus strobes
   // ------------------------------------------------------------
   wire wr_ctrl = reg_wr && (reg_addr == `CWSD_OFF_CTRL);
   wire wr_pol = reg_wr && (reg_addr == `CWSD_OFF_POL);
   wire wr_dbr = reg_wr && (reg_addr == `CWSD_OFF_DBR);
   wire wr_mask = reg_wr && (reg_addr == `CWSD_OFF_IRQ_MASK);
   wire rd_stat = reg_rd && (reg_addr == `CWSD_OFF_IRQ_STAT);

   // ------------------------------------------------------------
   // input source selection
   // ------------------------------------------------------------
   // vector index equals the select code, so the mux is one bit-select
   wire [7:0] src_vec = {logic_cell1_output, num_osc_output,
                         pwm_unit4_output, pwm_unit3_output,
                         pwm_unit2_output, pwm_unit1_output,
                         comparator2_async_output, comparator1_async_output};
   wire src_sel = src_vec[ctrl.input_source_select]; // R08

   // normal complementary waveform, polarity applied
   wire normal_a = src_sel ^ out_a_polarity; // R11
   wire normal_b = ~src_sel ^ out_b_polarity; // R11

   // ------------------------------------------------------------
   // shutdown edges and dead band
   // ------------------------------------------------------------
   wire sd = shutdown_event_status;
   wire sd_enter = sd && !sd_prev;
   wire sd_exit = !sd && sd_prev;
   wire db_done;
   wire db_done_rise = db_done && !db_done_prev;

   // one counter serves both pins; both share the rising dead band
   cwsd_deadband u_deadband (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(sd_enter),
      .abort(!sd),
      .count(rising_deadband_count),
      .done(db_done)
   ); // R12

   // ------------------------------------------------------------
   // shutdown drive of one pin
   // ------------------------------------------------------------
   function automatic cwsd_pin_t sd_drive(input cwsd_sd_code_t code, input logic normal,
                                          input logic pol, input logic dead_done);
      cwsd_pin_t pin;
      pin.level = 1'b0;
      pin.oe = 1'b1;
      unique case (code)
         CWSD_SD_HIGH: pin.level = 1'b1;
         CWSD_SD_LOW: pin.level = 1'b0;
         CWSD_SD_TRISTATE: pin.oe = 1'b0;
         CWSD_SD_INACTIVE: pin.level = dead_done ? pol : normal;
      endcase
      return pin;
   endfunction : sd_drive

   // next pin values: shutdown fields only while the event is present
   wire cwsd_pin_t sd_a = sd_drive(ctrl.out_a_shutdown_state, normal_a, out_a_polarity, db_done); // R05 R06 R07
   wire cwsd_pin_t sd_b = sd_drive(ctrl.out_b_shutdown_state, normal_b, out_b_polarity, db_done); // R02 R03 R04
   wire cwsd_pin_t next_pin_a = sd ? sd_a : cwsd_pin_t'{level: normal_a, oe: 1'b1}; // R01
   wire cwsd_pin_t next_pin_b = sd ? sd_b : cwsd_pin_t'{level: normal_b, oe: 1'b1}; // R01

   // ------------------------------------------------------------
   // interrupt status
   // ------------------------------------------------------------
   wire [`CWSD_IRQ_W-1:0] irq_events = {db_done_rise, sd_exit, sd_enter};
   // an event in the read-clear cycle survives: set wins
   wire [`CWSD_IRQ_W-1:0] next_irq_stat = (rd_stat ? `CWSD_IRQ_RST : irq_stat) | irq_events;

   // ------------------------------------------------------------
   // read data select
   // ------------------------------------------------------------
   wire [7:0] rd_ctrl = ctrl & `CWSD_CTRL_WMASK; // R09 R10
   wire [7:0] rd_pol = {6'h00, out_b_polarity, out_a_polarity};
   wire [7:0] rd_pins = {2'h0, sd, db_done, output_pin_b.oe, output_pin_b.level,
                         output_pin_a.oe, output_pin_a.level};
   wire [7:0] rd_mux =
      (reg_addr == `CWSD_OFF_CTRL) ? rd_ctrl :
      (reg_addr == `CWSD_OFF_POL) ? rd_pol :
      (reg_addr == `CWSD_OFF_DBR) ? {2'h0, rising_deadband_count} :
      (reg_addr == `CWSD_OFF_IRQ_STAT) ? {5'h00, irq_stat} :
      (reg_addr == `CWSD_OFF_IRQ_MASK) ? {5'h00, irq_mask} :
      (reg_addr == `CWSD_OFF_PIN_STAT) ? rd_pins : 8'h00;

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   // bit 3 is never stored, so it cannot leak back on a read
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `CWSD_CTRL_RST;
         {out_b_polarity, out_a_polarity} <= `CWSD_POL_RST;
         rising_deadband_count <= `CWSD_DBR_RST;
         irq_mask <= `CWSD_IRQ_RST;
      end else begin
         if (wr_ctrl) ctrl <= reg_wdata & `CWSD_CTRL_WMASK; // R09 R10
         if (wr_pol) {out_b_polarity, out_a_polarity} <= reg_wdata[`CWSD_POL_B_BIT:`CWSD_POL_A_BIT];
         if (wr_dbr) rising_deadband_count <= reg_wdata[`CWSD_DBR_W-1:0];
         if (wr_mask) irq_mask <= reg_wdata[`CWSD_IRQ_W-1:0];
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // block state and pins
   // ------------------------------------------------------------
   // pins reset driven low rather than floating the switches
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_pin_a <= '{level: 1'b0, oe: 1'b1};
         output_pin_b <= '{level: 1'b0, oe: 1'b1};
         sd_prev <= 1'b0;
         db_done_prev <= 1'b0;
         irq_stat <= `CWSD_IRQ_RST;
      end else begin
         output_pin_a <= next_pin_a;
         output_pin_b <= next_pin_b;
         sd_prev <= sd;
         db_done_prev <= db_done;
         irq_stat <= next_irq_stat;
      end
   end

   // level interrupt, high while any unmasked bit is set
   assign irq = |(irq_stat & irq_mask);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_NORMAL_FOLLOW: assert property ( // R01
      !sd |=> (output_pin_a.level == $past(normal_a)) && output_pin_a.oe
              && (output_pin_b.level == $past(normal_b)) && output_pin_b.oe)
      else $error("pins not following the normal waveform");

   AST_B_FORCED: assert property ( // R02
      sd && ctrl.out_b_shutdown_state[1] |=>
         output_pin_b.oe && (output_pin_b.level == $past(ctrl.out_b_shutdown_state[0])))
      else $error("pin B not forced to its shutdown level");

   AST_B_TRISTATE: assert property ( // R03
      sd && (ctrl.out_b_shutdown_state == CWSD_SD_TRISTATE) |=> !output_pin_b.oe)
      else $error("pin B driven while tri-state selected");

   AST_B_INACTIVE: assert property ( // R04
      sd && db_done && (ctrl.out_b_shutdown_state == CWSD_SD_INACTIVE) |=>
         output_pin_b.oe && (output_pin_b.level == $past(out_b_polarity)))
      else $error("pin B not at its inactive level after dead band");

   AST_A_FORCED: assert property ( // R05
      sd && ctrl.out_a_shutdown_state[1] |=>
         output_pin_a.oe && (output_pin_a.level == $past(ctrl.out_a_shutdown_state[0])))
      else $error("pin A not forced to its shutdown level");

   AST_A_TRISTATE: assert property ( // R06
      sd && (ctrl.out_a_shutdown_state == CWSD_SD_TRISTATE) |=> !output_pin_a.oe)
      else $error("pin A driven while tri-state selected");

   AST_A_INACTIVE: assert property ( // R07
      sd && db_done && (ctrl.out_a_shutdown_state == CWSD_SD_INACTIVE) |=>
         output_pin_a.oe && (output_pin_a.level == $past(out_a_polarity)))
      else $error("pin A not at its inactive level after dead band");

   AST_A_HOLD_IN_DB: assert property ( // R07
      sd && !db_done && (ctrl.out_a_shutdown_state == CWSD_SD_INACTIVE) |=>
         output_pin_a.level == $past(normal_a))
      else $error("pin A left the waveform before the dead band ended");

   AST_SRC_PWM1: assert property ( // R08
      !sd && (ctrl.input_source_select == 3'h2) |=>
         output_pin_a.level == ($past(pwm_unit1_output) ^ $past(out_a_polarity)))
      else $error("source select does not route the first pwm unit");

   AST_BIT3_READ: assert property ( // R09
      reg_rd && (reg_addr == `CWSD_OFF_CTRL) |=> !reg_rdata[3])
      else $error("control bit 3 read back as one");

   AST_CTRL_FIELDS: assert property ( // R10
      wr_ctrl ##1 !reg_wr ##1 (reg_rd && (reg_addr == `CWSD_OFF_CTRL) && !reg_wr) |=>
         reg_rdata == ($past(reg_wdata, 3) & 8'hf7))
      else $error("control fields not read back at their bit positions");

   AST_DB_BOUND: assert property ( // R12
      sd_enter |-> ##[1:65] (db_done || !sd))
      else $error("dead band longer than its programmed count");

   AST_DB_ZERO: assert property ( // R12
      sd_enter && (rising_deadband_count == 6'h00) |=> db_done || !sd)
      else $error("zero dead band still delayed the inactive state");

   AST_DB_NOT_EARLY: assert property ( // R12
      sd_enter && (rising_deadband_count == 6'h03) |=> !db_done [*3])
      else $error("dead band ended early");

   AST_IRQ_SET_WINS: assert property (
      rd_stat && sd_enter |=> irq_stat[`CWSD_IRQ_SD_ENTER])
      else $error("shutdown entry lost in read-clear cycle");

   AST_B_HOLD_IN_DB: assert property ( // R04
      sd && !db_done && (ctrl.out_b_shutdown_state == CWSD_SD_INACTIVE) |=>
         output_pin_b.level == $past(normal_b))
      else $error("pin B left the waveform before the dead band ended");

   AST_PAIR_COMPLEMENT: assert property ( // R11
      !sd |=> (output_pin_a.level ^ output_pin_b.level) == !($past(out_a_polarity) ^ $past(out_b_polarity)))
      else $error("outputs not complementary under their polarities");

   AST_SRC_OSC: assert property ( // R08
      !sd && (ctrl.input_source_select == 3'h6) |=>
         output_pin_a.level == ($past(num_osc_output) ^ $past(out_a_polarity)))
      else $error("source select does not route the oscillator");

   AST_POL_WRITE: assert property ( // R11
      wr_pol |=> {out_b_polarity, out_a_polarity} == $past(reg_wdata[1:0]))
      else $error("polarity write not stored");

   AST_DB_ABORT: assert property ( // R01
      !sd |=> !db_done)
      else $error("dead band still running without a shutdown");

   AST_DBR_READ: assert property ( // R12
      reg_rd && (reg_addr == `CWSD_OFF_DBR) |=> reg_rdata[7:6] == 2'h0)
      else $error("dead band count read back wider than six bits");

   AST_RDATA_IDLE: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data present without a read strobe");

   AST_STAT_ENTER: assert property (
      sd_enter |=> irq_stat[`CWSD_IRQ_SD_ENTER])
      else $error("shutdown entry not recorded");

   AST_STAT_EXIT: assert property (
      sd_exit |=> irq_stat[`CWSD_IRQ_SD_EXIT])
      else $error("shutdown exit not recorded");

   AST_STAT_DB: assert property (
      db_done_rise |=> irq_stat[`CWSD_IRQ_DB_DONE])
      else $error("dead band end not recorded");

   AST_STAT_STICKY: assert property (
      !rd_stat |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
      else $error("status bit lost without a read");

   AST_RD_CLEAR: assert property (
      rd_stat && (irq_events == 3'h0) |=> irq_stat == 3'h0)
      else $error("status not cleared by its read");

   CV_SD_TRISTATE: cover property (sd_enter && ctrl.out_a_shutdown_state == CWSD_SD_TRISTATE);
   CV_SD_INACTIVE: cover property (sd && db_done && ctrl.out_b_shutdown_state == CWSD_SD_INACTIVE);
   CV_IRQ: cover property ($rose(irq));
   CV_SD_ABORT: cover property (sd_enter ##1 !sd [*2]);
   CV_SET_WINS: cover property (rd_stat && sd_enter);

endmodule : cwsd_top

// ### cwsd_switch_model.sv
// ------------------------------------------------------------
// power switch pair on the two output pins
// ------------------------------------------------------------
module cwsd_switch_model (
   // clock
   input wire logic sys_clk,
   // pins from the generator
   input wire cwsd_pkg::cwsd_pin_t pin_a,
   input wire cwsd_pkg::cwsd_pin_t pin_b,
   // gate levels seen by the switches
   output logic line_a,
   output logic line_b
);
   timeunit 1ns;
   timeprecision 1ps;
   import cwsd_pkg::*;

   logic flt_a = 1'b0;
   logic flt_b = 1'b0;

   // no pull on the gates: a released line wanders, never holds the last value
   always @(posedge sys_clk) begin
      flt_a <= pin_a.oe ? ~pin_a.level : ~flt_a;
      flt_b <= pin_b.oe ? ~pin_b.level : ~flt_b;
   end

   // driven level wins, else the wandering level
   assign line_a = pin_a.oe ? pin_a.level : flt_a;
   assign line_b = pin_b.oe ? pin_b.level : flt_b;
endmodule : cwsd_switch_model

// ### waveform_shutdown_input_select_test.sv
module waveform_shutdown_input_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   import cwsd_pkg::*;

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [7:0] src;
   logic sde;
   cwsd_pin_t pa;
   cwsd_pin_t pb;
   logic irq;
   logic line_a;
   logic line_b;
   int errors = 0;
   int compares = 0;
   int cnt;
   logic [1:0] e;

   cwsd_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comparator1_async_output(src[0]),
      .comparator2_async_output(src[1]), .pwm_unit1_output(src[2]), .pwm_unit2_output(src[3]),
      .pwm_unit3_output(src[4]), .pwm_unit4_output(src[5]), .num_osc_output(src[6]),
      .logic_cell1_output(src[7]), .shutdown_event_status(sde), .output_pin_a(pa),
      .output_pin_b(pb), .irq(irq));

   cwsd_switch_model i_sw (.sys_clk(sys_clk), .pin_a(pa), .pin_b(pb), .line_a(line_a), .line_b(line_b));

   // 100 MHz clock
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task chk_val(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   // tristated pins are judged by enable only, their level is meaningless
   task chk_pin(input cwsd_pin_t ea, input cwsd_pin_t eb);
      chk_val({6'h00, ea.oe ? pa : {1'b0, pa.oe}}, {6'h00, ea.oe ? ea : 2'b00});
      chk_val({6'h00, eb.oe ? pb : {1'b0, pb.oe}}, {6'h00, eb.oe ? eb : 2'b00});
      if (ea.oe) chk_val({7'h00, line_a}, {7'h00, ea.level});
      if (eb.oe) chk_val({7'h00, line_b}, {7'h00, eb.level});
   endtask : chk_pin

   task wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wt

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr_reg

   // data stand only in the cycle after the strobe
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk_val(reg_rdata, exp);
   endtask : rd_chk

   task end_sim;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   // watchdog, run is under two hundred cycles
   initial begin
      #200us;
      errors++;
      end_sim();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      src = 8'h00;
      sde = 1'b0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      // reset values, unmapped read, read-only pin status
      for (int a = 0; a < 5; a++) rd_chk(a[7:0], 8'h00);
      rd_chk(8'h05, 8'h0e);
      wr_reg(8'h05, 8'hff);
      rd_chk(8'h05, 8'h0e);
      rd_chk(8'h09, 8'h00);
      chk_val({7'h00, irq}, 8'h00);
      // bit 3 dropped, fields in place
      wr_reg(8'h00, 8'hff);
      rd_chk(8'h00, 8'hf7);
      wr_reg(8'h00, 8'h9a);
      rd_chk(8'h00, 8'h92);
      $display("test registers done");
      // every source code, both source levels
      for (int s = 0; s < 8; s++) begin
         wr_reg(8'h00, s[7:0]);
         src <= 8'h01 << s;
         wt(2);
         chk_pin(2'b11, 2'b01);
         src <= ~(8'h01 << s);
         wt(2);
         chk_pin(2'b01, 2'b11);
      end
      wr_reg(8'h01, 8'h03);
      src <= 8'h80;
      wt(2);
      chk_pin(2'b01, 2'b11);
      $display("test sources done");
      // forced and tri-state codes with both polarities set
      wr_reg(8'h00, 8'h00);
      src <= 8'h01;
      for (int c = 3; c > 0; c--) begin
         wr_reg(8'h00, c[7:0] * 8'h50);
         wt(2);
         chk_pin(2'b01, 2'b11);
         sde <= 1'b1;
         e = (c == 3) ? 2'b11 : (c == 2) ? 2'b01 : 2'b00;
         wt(2);
         chk_pin(e, e);
         chk_val({7'h00, irq}, 8'h00);
         sde <= 1'b0;
         wt(2);
         chk_pin(2'b01, 2'b11);
      end
      $display("test forced states done");
      // inactive state after the dead band, irq on entry, end and exit
      wr_reg(8'h00, 8'h00);
      wr_reg(8'h01, 8'h01);
      wr_reg(8'h04, 8'h07);
      // forced and tri-state runs left entry, exit and dead band end pending
      rd_chk(8'h03, 8'h07);
      for (int n = 0; n < 6; n += 3) begin
         wr_reg(8'h02, n[7:0]);
         rd_chk(8'h02, n[7:0]);
         wt(2);
         rd_chk(8'h03, 8'h00);
         @(posedge sys_clk);
         sde <= 1'b1;
         cnt = 0;
         while (pa !== 2'b11 && cnt < 20) begin
            wt(1);
            cnt++;
         end
         chk_val(cnt[7:0], n[7:0] + 8'h02);
         chk_pin(2'b11, 2'b01);
         chk_val({7'h00, irq}, 8'h01);
         rd_chk(8'h03, 8'h05);
         rd_chk(8'h03, 8'h00);
         chk_val({7'h00, irq}, 8'h00);
         sde <= 1'b0;
         wt(2);
         chk_pin(2'b01, 2'b01);
         rd_chk(8'h03, 8'h02);
      end
      // shutdown dropped before the dead band ends, entry beside a status read
      wr_reg(8'h02, 8'h05);
      @(posedge sys_clk);
      sde <= 1'b1;
      reg_addr <= 8'h03;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk_val(reg_rdata, 8'h00);
      wt(2);
      chk_pin(2'b01, 2'b01);
      sde <= 1'b0;
      wt(8);
      chk_pin(2'b01, 2'b01);
      rd_chk(8'h03, 8'h03);
      $display("test dead band done");
      end_sim();
   end
endmodule : waveform_shutdown_input_select_test
